// *** rtl/arrc_pkg.sv ***
// Constants for the converter reset and ready control block.
// Assumes a single clock domain and a byte-wide command interface.
package arrc_pkg;
  // =====================================================================
  // Charge pump
  localparam int unsigned PUMP_DIV = 64;
  localparam int unsigned PUMP_HALF = PUMP_DIV / 2;
  // =====================================================================
  // Command recovery and command codes
  localparam int unsigned ZERO_RUN = 4;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RD_STATUS = 4'h1;
  localparam logic [3:0] CMD_START = 4'hf;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // =====================================================================
  // Status byte layout and configuration latch count
  localparam int unsigned STAT_READY_BIT = 7;
  localparam int unsigned CFG_COUNT = 5;
endpackage : arrc_pkg

// *** rtl/arrc_cfg_mem.sv ***
// Holds the configuration latches written over the serial link.
// Assumes write strobes come from the same clock; no reset clears it.
`timescale 1ns/10ps
module arrc_cfg_mem #(
  parameter int unsigned DEPTH = 5,
  parameter int unsigned AW = 3
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("arrc_cfg_mem: depth does not fit the address");
  end

  // =====================================================================
  // Latches with registered read; not reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : arrc_cfg_mem

// *** rtl/arrc_top.sv ***
// Reset, recovery, ready and charge pump control of the converter.
// Assumes byte-level command traffic arrives as pulses on clk and the
// reset pin and serial input pin come from outside this clock domain.
//
// Behaviour
// - Reset low puts the serial interface in command-waiting state.
// - Reset aborts running conversion and idles the sequencer.
// - Four consecutive zero bytes return interface to command waiting.
// - Configuration latches survive reset; only serial writes change them.
// - Ready output low throughout a conversion.
// - Ready output high once a conversion completes.
// - Ready pin equals the ready flag readable over serial.
// - Charge pump clock is main clock divided by sixty-four.
// - Ready flag appears as a bit of the status byte.
// - Config write during conversion aborts it; data still latched.
`timescale 1ns/10ps
module arrc_top #(
  parameter int unsigned ZERO_RUN = arrc_pkg::ZERO_RUN,
  parameter int unsigned PUMP_DIV = arrc_pkg::PUMP_DIV
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic serial_in_pin,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic conv_done,
  input wire logic [3:0] aux_in,
  output logic conversion_ready,
  output logic [7:0] status_byte,
  output logic cmd_waiting,
  output logic conv_busy,
  output logic cfg_wr_en,
  output logic [2:0] cfg_rd_addr_out,
  output logic [7:0] cfg_rd_data,
  output logic pump_clk,
  output logic serial_in_sync
);
  if (ZERO_RUN < 1 || ZERO_RUN > 14 || PUMP_DIV < 2 || PUMP_DIV > 512 ||
      PUMP_DIV % 2 != 0) begin : g_bad_params
    $error("arrc_top: parameter out of range");
  end

  typedef enum logic [2:0] {
    ARRC_CMD = 3'h1,
    ARRC_WRITE = 3'h2,
    ARRC_READ = 3'h4
  } arrc_if_t;

  typedef enum logic [1:0] {
    ARRC_IDLE = 2'h1,
    ARRC_CONV = 2'h2
  } arrc_cv_t;

  function automatic logic [1:0] arrc_len(input logic [3:0] code);
    unique case (code)
      4'h5, 4'he: arrc_len = 2'h3;
      4'ha: arrc_len = 2'h2;
      4'h0, 4'h6, 4'h7, 4'hf: arrc_len = 2'h0;
      default: arrc_len = 2'h1;
    endcase
  endfunction : arrc_len

  function automatic logic [2:0] arrc_base(input logic [3:0] code);
    unique case (code)
      4'h9: arrc_base = 3'h1;
      4'hb, 4'he: arrc_base = 3'h2;
      4'hc: arrc_base = 3'h3;
      4'hd: arrc_base = 3'h4;
      default: arrc_base = 3'h0;
    endcase
  endfunction : arrc_base

  // =====================================================================
  // Pin synchronisers
  logic [1:0] rst_meta;
  logic [1:0] next_rst_meta;
  logic [1:0] si_meta;
  logic [1:0] next_si_meta;
  logic [7:0] aux_meta;
  logic [7:0] next_aux_meta;
  logic pin_reset;

  always_comb begin
    next_rst_meta = {rst_meta[0], reset_pin_n};
    next_si_meta = {si_meta[0], serial_in_pin};
    next_aux_meta = {aux_meta[3:0], aux_in};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 2'h3;
      si_meta <= 2'h0;
      aux_meta <= 8'h00;
    end else begin
      rst_meta <= next_rst_meta;
      si_meta <= next_si_meta;
      aux_meta <= next_aux_meta;
    end
  end

  assign pin_reset = ~rst_meta[1];
  assign serial_in_sync = si_meta[1];

  // =====================================================================
  // Serial command state
  arrc_if_t if_state;
  arrc_if_t next_if_state;
  logic [1:0] left;
  logic [1:0] next_left;
  logic [2:0] addr;
  logic [2:0] next_addr;
  logic [3:0] zero_cnt;
  logic [3:0] next_zero_cnt;
  logic zero_force;
  logic start_req;
  logic cfg_write;

  always_comb begin
    next_if_state = if_state;
    next_left = left;
    next_addr = addr;
    next_zero_cnt = zero_cnt;
    zero_force = 1'b0;
    start_req = 1'b0;
    cfg_write = 1'b0;
    if (byte_valid) begin
      if (byte_data == arrc_pkg::ZERO_BYTE) begin
        if (zero_cnt < 4'(ZERO_RUN)) begin
          next_zero_cnt = zero_cnt + 4'h1;
        end
        zero_force = (zero_cnt + 4'h1) >= 4'(ZERO_RUN);
      end else begin
        next_zero_cnt = 4'h0;
      end
      unique case (if_state)
        ARRC_CMD: begin
          next_left = arrc_len(byte_data[3:0]);
          next_addr = arrc_base(byte_data[3:0]);
          start_req = byte_data[3:0] == arrc_pkg::CMD_START;
          if (arrc_len(byte_data[3:0]) != 2'h0) begin
            next_if_state = byte_data[3] ? ARRC_WRITE : ARRC_READ;
          end
        end
        ARRC_WRITE, ARRC_READ: begin
          cfg_write = if_state == ARRC_WRITE;
          next_addr = addr + 3'h1;
          next_left = left - 2'h1;
          if (left == 2'h1) begin
            next_if_state = ARRC_CMD;
          end
        end
      endcase
      if (zero_force) begin
        next_if_state = ARRC_CMD;
        next_left = 2'h0;
        start_req = 1'b0;
        cfg_write = 1'b0;
      end
    end
    if (pin_reset) begin
      next_if_state = ARRC_CMD;
      next_left = 2'h0;
      next_zero_cnt = 4'h0;
      start_req = 1'b0;
      cfg_write = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      if_state <= ARRC_CMD;
      left <= 2'h0;
      addr <= 3'h0;
      zero_cnt <= 4'h0;
    end else begin
      if_state <= next_if_state;
      left <= next_left;
      addr <= next_addr;
      zero_cnt <= next_zero_cnt;
    end
  end

  assign cmd_waiting = if_state == ARRC_CMD;
  assign cfg_wr_en = cfg_write;

  // =====================================================================
  // Configuration latches
  arrc_cfg_mem #(
    .DEPTH(arrc_pkg::CFG_COUNT),
    .AW(3)
  ) u_cfg (
    .clk(clk),
    .wr_en(cfg_write),
    .wr_addr(addr),
    .wr_data(byte_data),
    .rd_addr(addr),
    .rd_data(cfg_rd_data)
  );
  assign cfg_rd_addr_out = addr;

  // =====================================================================
  // Conversion sequencer and ready flag
  arrc_cv_t cv_state;
  arrc_cv_t next_cv_state;
  logic ready;
  logic next_ready;

  always_comb begin
    next_cv_state = cv_state;
    next_ready = ready;
    unique case (cv_state)
      ARRC_IDLE: begin
        if (start_req) begin
          next_cv_state = ARRC_CONV;
          next_ready = 1'b0;
        end
      end
      ARRC_CONV: begin
        if (cfg_write) begin
          next_cv_state = ARRC_IDLE;
        end else if (conv_done) begin
          next_cv_state = ARRC_IDLE;
          next_ready = 1'b1;
        end
      end
    endcase
    if (pin_reset) begin
      next_cv_state = ARRC_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cv_state <= ARRC_IDLE;
      ready <= 1'b0;
    end else begin
      cv_state <= next_cv_state;
      ready <= next_ready;
    end
  end

  assign conv_busy = cv_state == ARRC_CONV;
  assign conversion_ready = ready;

  // =====================================================================
  // Status byte
  logic [7:0] next_status;
  always_comb begin
    next_status = {4'h0, aux_meta[7:4]};
    next_status[arrc_pkg::STAT_READY_BIT] = next_ready;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= next_status;
    end
  end

  // =====================================================================
  // Charge pump divider
  localparam int unsigned HALF = PUMP_DIV / 2;
  logic [7:0] pump_cnt;
  logic [7:0] next_pump_cnt;
  logic next_pump_clk;

  always_comb begin
    if (pump_cnt == 8'(HALF - 1)) begin
      next_pump_cnt = 8'h00;
      next_pump_clk = ~pump_clk;
    end else begin
      next_pump_cnt = pump_cnt + 8'h01;
      next_pump_clk = pump_clk;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pump_cnt <= 8'h00;
      pump_clk <= 1'b0;
    end else begin
      pump_cnt <= next_pump_cnt;
      pump_clk <= next_pump_clk;
    end
  end
endmodule : arrc_top

// *** sim/arrc_props.sv ***
// Checker on the ports of the reset and ready control.
// Assumes it is bound to arrc_top and sees only its ports.
`timescale 1ns/10ps
module arrc_props #(
  parameter int unsigned ZERO_RUN = 4,
  parameter int unsigned PUMP_DIV = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic serial_in_pin,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic conv_done,
  input wire logic [3:0] aux_in,
  input wire logic conversion_ready,
  input wire logic [7:0] status_byte,
  input wire logic cmd_waiting,
  input wire logic conv_busy,
  input wire logic cfg_wr_en,
  input wire logic [2:0] cfg_rd_addr_out,
  input wire logic [7:0] cfg_rd_data,
  input wire logic pump_clk,
  input wire logic serial_in_sync
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence start_s;
    byte_valid && byte_data == 8'h0f && cmd_waiting && !conv_busy;
  endsequence
  ready_mirror_a: assert property (status_byte[7] == conversion_ready)
    else $error("ready pin differs from status bit");
  busy_ready_a: assert property (conv_busy |-> !conversion_ready)
    else $error("ready high while converting");
  start_conv_a:
    assert property (reset_pin_n[*3] ##0 start_s |=>
      conv_busy && !conversion_ready)
    else $error("start did not begin a conversion");
  done_ready_a:
    assert property (reset_pin_n[*3] ##0 (conv_busy && conv_done && !cfg_wr_en)
      |=> conversion_ready && !conv_busy)
    else $error("done did not raise ready");
  pin_reset_a:
    assert property (!reset_pin_n[*4] |-> cmd_waiting && !conv_busy)
    else $error("pin reset did not idle interface");
  cfg_abort_a:
    assert property (cfg_wr_en && conv_busy |=> !conv_busy && !conversion_ready)
    else $error("config write did not abort");
  cfg_source_a:
    assert property (cfg_wr_en |-> byte_valid && !cmd_waiting)
    else $error("latch write without serial data");
  // =====================================================================
  // Pump phase length counter
  localparam int unsigned PUMP_HALF = PUMP_DIV / 2;
  logic pump_prev;
  int unsigned pump_run;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pump_prev <= 1'b0;
      pump_run <= 32'h0;
    end else begin
      pump_prev <= pump_clk;
      pump_run <= (pump_clk == pump_prev) ? pump_run + 32'h1 : 32'h1;
    end
  end
  pump_edge_a:
    assert property (pump_clk != pump_prev |-> pump_run == PUMP_HALF)
    else $error("pump phase length wrong");
  pump_hold_a: assert property (pump_run <= PUMP_HALF)
    else $error("pump phase too long");
  cover property (start_s);
  cover property (conv_busy && conv_done);
  cover property (cfg_wr_en && conv_busy);
endmodule : arrc_props

// *** sim/arrc_host.sv ***
// Host model: turns each request into a one-cycle byte strobe.
// Assumes requests are raised for a single clock.
`timescale 1ns/10ps
module arrc_host (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] send_data,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  always @(posedge clk) begin
    byte_valid <= #1 send;
    byte_data <= #1 send ? send_data : ~byte_data;
  end
endmodule : arrc_host

// *** sim/test_adc_reset_ready_control.sv ***
// Bench for the reset and ready control, bytes fed by the host model.
// Assumes a byte is taken two edges after its request.
`timescale 1ns/10ps
module test_adc_reset_ready_control;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic serial_in_pin = 1'b0;
  logic conv_done = 1'b0;
  logic [3:0] aux_in = 4'h0;
  logic send = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic byte_valid, cmd_waiting, conv_busy, cfg_wr_en, conversion_ready;
  logic pump_clk, serial_in_sync;
  logic [7:0] byte_data, status_byte, cfg_rd_data;
  logic [2:0] cfg_rd_addr_out;
  logic [7:0] cfg [5];
  bit seen [5];
  logic rdy = 1'b0;
  logic busy = 1'b0;
  logic wr = 1'b0;
  logic [1:0] si_hist = 2'h0;
  int rem, idx, zc, wr_exp, wr_seen, pump_n, mismatches, comparisons;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    serial_in_pin <= #1 1'($urandom);
    si_hist <= reset_n ? {si_hist[0], serial_in_pin} : 2'h0;
    pump_n <= reset_n ? pump_n + 1 : 0;
    if (cfg_wr_en === 1'b1) begin
      wr_seen <= wr_seen + 1;
    end
  end
  arrc_host host (.clk(clk), .send(send), .send_data(send_data),
    .byte_valid(byte_valid), .byte_data(byte_data));
  arrc_top #(.ZERO_RUN(arrc_pkg::ZERO_RUN), .PUMP_DIV(arrc_pkg::PUMP_DIV))
    DUT (.clk(clk), .reset_n(reset_n),
    .reset_pin_n(reset_pin_n), .serial_in_pin(serial_in_pin),
    .byte_valid(byte_valid), .byte_data(byte_data), .conv_done(conv_done),
    .aux_in(aux_in), .conversion_ready(conversion_ready),
    .status_byte(status_byte), .cmd_waiting(cmd_waiting),
    .conv_busy(conv_busy), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_addr_out(cfg_rd_addr_out), .cfg_rd_data(cfg_rd_data),
    .pump_clk(pump_clk), .serial_in_sync(serial_in_sync));
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task check_state;
    logic [2:0] a;
    logic pump_exp;
    a = cfg_rd_addr_out;
    pump_exp = 1'((pump_n / arrc_pkg::PUMP_HALF) % 2);
    chk("cmd_waiting", 8'(rem == 0), 8'(cmd_waiting));
    chk("conv_busy", 8'(busy), 8'(conv_busy));
    chk("ready", 8'(rdy), 8'(conversion_ready));
    chk("status", {rdy, 3'h0, aux_in}, status_byte);
    chk("writes", 8'(wr_exp), 8'(wr_seen));
    chk("serial_in_sync", 8'(si_hist[1]), 8'(serial_in_sync));
    chk("pump_clk", 8'(pump_exp), 8'(pump_clk));
    if (a < 5 && seen[a]) begin
      chk("cfg_rd_data", cfg[a], cfg_rd_data);
    end
  endtask : check_state
  task model_byte(input logic [7:0] b);
    zc = (b == 8'h00) ? zc + 1 : 0;
    if (zc >= 4) begin
      rem = 0;
    end else if (rem > 0) begin
      rem--;
      if (wr) begin
        cfg[idx] = b;
        seen[idx] = 1'b1;
        idx++;
        wr_exp++;
        busy = 1'b0;
      end
    end else if (b[3:0] == 4'hf) begin
      rdy = busy ? rdy : 1'b0;
      busy = 1'b1;
    end else begin
      wr = b[3];
      case (b[3:0])
        4'h5, 4'he: rem = 3;
        4'ha: rem = 2;
        4'h0, 4'h6, 4'h7: rem = 0;
        default: rem = 1;
      endcase
      case (b[3:0])
        4'h9: idx = 1;
        4'hb, 4'he: idx = 2;
        4'hc: idx = 3;
        4'hd: idx = 4;
        default: idx = 0;
      endcase
    end
  endtask : model_byte
  task put(input logic [7:0] b);
    @(posedge clk);
    #1 send = 1'b1;
    send_data = b;
    aux_in = 4'($urandom);
    @(posedge clk);
    #1 send = 1'b0;
    model_byte(b);
    repeat (2) @(posedge clk);
    #2 check_state();
  endtask : put
  task done_pulse;
    @(posedge clk);
    #1 conv_done = 1'b1;
    @(posedge clk);
    #1 conv_done = 1'b0;
    rdy = busy ? 1'b1 : rdy;
    busy = 1'b0;
    @(posedge clk);
    #2 check_state();
  endtask : done_pulse
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(32'h10f1));
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    @(posedge clk);
    #2 check_state();
    $display("test reset done");
    put(8'h0f);
    done_pulse();
    put(8'h0f);
    put(8'h0b);
    put(8'($urandom));
    $display("test abort done");
    for (int c = 0; c < 16; c++) begin
      put(8'(c));
      while (rem > 0) put(8'($urandom));
      done_pulse();
    end
    $display("test codes done");
    put(8'h0e);
    put(8'h0f);
    @(posedge clk);
    #1 reset_pin_n = 1'b0;
    rem = 0;
    zc = 0;
    busy = 1'b0;
    repeat (6) @(posedge clk);
    #1 check_state();
    reset_pin_n = 1'b1;
    repeat (3) @(posedge clk);
    put(8'h0f);
    $display("test pin reset done");
    put(8'h0e);
    put(8'h5a);
    for (int i = 0; i < 6; i++) put(8'h00);
    $display("test zero run done");
    final_report();
  end
endmodule : test_adc_reset_ready_control
bind arrc_top arrc_props #(.ZERO_RUN(ZERO_RUN), .PUMP_DIV(PUMP_DIV)) props (
  .clk(clk), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
  .serial_in_pin(serial_in_pin), .byte_valid(byte_valid),
  .byte_data(byte_data), .conv_done(conv_done), .aux_in(aux_in),
  .conversion_ready(conversion_ready), .status_byte(status_byte),
  .cmd_waiting(cmd_waiting), .conv_busy(conv_busy), .cfg_wr_en(cfg_wr_en),
  .cfg_rd_addr_out(cfg_rd_addr_out), .cfg_rd_data(cfg_rd_data),
  .pump_clk(pump_clk), .serial_in_sync(serial_in_sync));
